// [verilog/dupsel_pkg.sv]
// Purpose: Shared constants for the dual serial and printer host select front end.
// Assumes: One clock, pclk at 250 MHz; host bus signals synchronous to it.
// Notes:   Register offsets and pattern values live here only.
package dupsel_pkg;
  // ----------------------------------------------------------------
  // Widths and offsets
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned ADDR_W        = 3;
  localparam logic [1:0]  PP_DATA_OFS   = 2'h0;
  localparam logic [1:0]  PP_STAT_OFS   = 2'h1;
  localparam logic [1:0]  PP_CTRL_OFS   = 2'h2;
  localparam logic [1:0]  PP_IOSEL_OFS  = 2'h3;
  localparam int unsigned CTRL_DIR_BIT  = 5;
  localparam int unsigned CTRL_ALF_BIT  = 1;
  localparam int unsigned STAT_BUSY_BIT = 7;
  localparam int unsigned STAT_ACK_BIT  = 6;
  localparam logic [7:0]  DIR_OUT_PAT   = 8'h55;
  localparam logic [7:0]  DIR_IN_PAT    = 8'haa;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  UART_RST      = 8'h00;
  // ----------------------------------------------------------------
  // APB controller register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_OFS       = 8'h00;
  localparam logic [7:0]  WDATA_OFS     = 8'h04;
  localparam logic [7:0]  STATUS_OFS    = 8'h08;
  localparam logic [7:0]  RDATA_OFS     = 8'h0c;
  localparam int unsigned CMD_GO_BIT    = 8;
  localparam int unsigned CMD_WR_BIT    = 9;
  localparam int unsigned CMD_CS_LSB    = 10;
  localparam logic [1:0]  CS_UART_A     = 2'h0;
  localparam logic [1:0]  CS_UART_B     = 2'h1;
  localparam logic [1:0]  CS_PRINTER    = 2'h2;
  localparam logic [2:0]  STROBE_CYC    = 3'h3;
endpackage

// [verilog/dupsel_if.sv]
// Purpose: Pin level link between the host controller and the device end.
// Assumes: Two-way pins are split into in, out and enable; the wire is resolved here.
// Notes:   No clocking block; both ends share pclk.
`timescale 1ns/100ps
interface dupsel_if;
  logic       uart_a_select_n;
  logic       uart_b_select_n;
  logic       printer_port_select_n;
  logic       host_read_strobe_n;
  logic       host_write_strobe_n;
  logic [2:0] addr;
  logic [7:0] host_dout;
  logic       host_doe;
  logic [7:0] dev_dout;
  logic       dev_doe;
  logic       read_active_out;
  logic [7:0] data_bus;

  assign data_bus = dev_doe ? dev_dout : (host_doe ? host_dout : 8'hff);

  modport host (
    output uart_a_select_n, uart_b_select_n, printer_port_select_n,
    output host_read_strobe_n, host_write_strobe_n, addr, host_dout, host_doe,
    input  data_bus, read_active_out
  );
  modport dev (
    input  uart_a_select_n, uart_b_select_n, printer_port_select_n,
    input  host_read_strobe_n, host_write_strobe_n, addr, data_bus,
    output dev_dout, dev_doe, read_active_out
  );
endinterface // dupsel_if

// [verilog/dupsel_uart_regs.sv]
// Purpose: Eight byte register window standing in for one serial channel.
// Assumes: Framing and baud logic sit elsewhere; only host access is modelled.
// Notes:   Shared by channels A and B.
`timescale 1ns/100ps
module dupsel_uart_regs (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       wr_en,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  logic [7:0] regs_ff [0:7];

  assign rdata = regs_ff[addr];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        regs_ff[i] <= dupsel_pkg::UART_RST;
      end
    end else if (wr_en) begin
      regs_ff[addr] <= wdata; // Bit 0 is the least significant.
    end
  end
endmodule // dupsel_uart_regs

// [verilog/dupsel_device.sv]
// Purpose: Device end: select decode, register access and printer port pins.
// Assumes: All host pins synchronous to pclk; writes take effect on the write strobe rising.
// Notes:   Several selects low at once resolve as A, then B, then printer.
//
// Function
// - Select A low opens channel A registers.
// - Select B low opens channel B registers.
// - Printer select low connects printer registers.
// - Strap low uses I/O select, high control bit.
// - Direction by control bit or pattern register.
// - Host bus driven only during reads.
// - Data bit 0 is least significant bit.
// - Three address lines select a channel register; the printer decodes only the lower two.
// - Printer acknowledge is active low, pulled up.
// - Printer busy high means not ready.
// - Auto line feed is open drain, low active.
// - Single external clock drives all logic.
// - Read strobe low places register on bus.
// - Read active output high during host reads.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module dupsel_device (
  input  wire logic       pclk,
  input  wire logic       presetn,
  dupsel_if.dev           bus,
  input  wire logic       direction_source_strap,
  input  wire logic       printer_ack_n,
  input  wire logic       printer_busy,
  input  wire logic [7:0] printer_data_lines_in,
  output logic      [7:0] printer_data_lines_out,
  output logic            printer_data_lines_oe,
  input  wire logic       auto_linefeed_n_in,
  output logic            auto_linefeed_n_out,
  output logic            auto_linefeed_n_oe
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One place decides an offset match, so the read and write decodes agree.
  function automatic logic pp_hit(input logic [1:0] ofs, input logic [1:0] want);
    pp_hit = (ofs == want);
  endfunction

  // Pattern decode: the out pattern, the in pattern, or keep the old direction.
  function automatic logic pattern_dir(input logic [7:0] wd, input logic cur);
    if (wd == dupsel_pkg::DIR_OUT_PAT) begin
      pattern_dir = 1'b1;
    end else if (wd == dupsel_pkg::DIR_IN_PAT) begin
      pattern_dir = 1'b0;
    end else begin
      pattern_dir = cur;
    end
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic       wr_dly_ff;
  logic       pp_dir_out_ff;
  logic       pp_iosel_dir_ff;
  logic       nxt_iosel_dir;
  logic [7:0] nxt_ctrl;
  logic [7:0] pp_data_q_ff;
  logic [7:0] pp_ctrl_q_ff;
  logic [7:0] dout_ff;
  logic [7:0] uart_a_rdata, uart_b_rdata;
  logic [7:0] nxt_dout;
  logic       nxt_dir_out;

  wire sel_a   = !bus.uart_a_select_n;
  wire sel_b   = !bus.uart_b_select_n;
  wire sel_p   = !bus.printer_port_select_n;
  wire any_sel = sel_a | sel_b | sel_p;
  wire rd_act  = any_sel & !bus.host_read_strobe_n;
  wire wr_lvl  = any_sel & !bus.host_write_strobe_n;
  // Overlapping selects would fight over the data bus, so one window wins.
  wire win_a   = sel_a;
  wire win_b   = sel_b & !sel_a;
  wire win_p   = sel_p & !sel_a & !sel_b;
  // Writes commit on the strobe's trailing edge so data is settled by then.
  wire wr_done = wr_dly_ff & !wr_lvl;
  logic [2:0] addr_ff;
  logic       wsel_a_ff, wsel_b_ff, wsel_p_ff;
  logic [7:0] wdata_ff;
  wire [1:0] pp_ofs = addr_ff[1:0];
  wire       pp_wr  = wr_done & wsel_p_ff;
  wire       dir_by_strap_bit = direction_source_strap;
  wire       pp_wr_data  = pp_wr & pp_hit(pp_ofs, dupsel_pkg::PP_DATA_OFS);
  wire       pp_wr_ctrl  = pp_wr & pp_hit(pp_ofs, dupsel_pkg::PP_CTRL_OFS);
  wire       pp_wr_iosel = pp_wr & pp_hit(pp_ofs, dupsel_pkg::PP_IOSEL_OFS);
  wire [1:0] rd_ofs      = bus.addr[1:0];
  // A write commits after its strobe has risen, so it needs the captured address.
  wire       chan_a_wr   = wr_done & wsel_a_ff;
  wire       chan_b_wr   = wr_done & wsel_b_ff;
  wire [2:0] chan_a_addr = chan_a_wr ? addr_ff : bus.addr;
  wire [2:0] chan_b_addr = chan_b_wr ? addr_ff : bus.addr;

  // ----------------------------------------------------------------
  // Channel register windows
  // ----------------------------------------------------------------
  dupsel_uart_regs u_chan_a (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (chan_a_wr),
    .addr    (chan_a_addr),
    .wdata   (wdata_ff),
    .rdata   (uart_a_rdata)
  );
  dupsel_uart_regs u_chan_b (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (chan_b_wr),
    .addr    (chan_b_addr),
    .wdata   (wdata_ff),
    .rdata   (uart_b_rdata)
  );

  // ----------------------------------------------------------------
  // Printer port
  // ----------------------------------------------------------------
  wire [7:0] pp_status = {printer_busy, printer_ack_n, 6'h00};
  wire [7:0] pp_rd_data =
    pp_hit(rd_ofs, dupsel_pkg::PP_DATA_OFS) ?
      (pp_dir_out_ff ? pp_data_q_ff : printer_data_lines_in) :
    pp_hit(rd_ofs, dupsel_pkg::PP_STAT_OFS) ? pp_status :
    pp_hit(rd_ofs, dupsel_pkg::PP_CTRL_OFS) ?
      {pp_ctrl_q_ff[7:2], !auto_linefeed_n_in, pp_ctrl_q_ff[0]} :
    {7'h00, pp_dir_out_ff};

  // ----------------------------------------------------------------
  // Printer direction
  // ----------------------------------------------------------------
  // The pattern register only listens while the strap selects it.
  assign nxt_iosel_dir = (pp_wr_iosel & !dir_by_strap_bit) ?
                         pattern_dir(wdata_ff, pp_iosel_dir_ff) : pp_iosel_dir_ff;
  assign nxt_ctrl      = pp_wr_ctrl ? wdata_ff : pp_ctrl_q_ff;
  // Direction tracks the selected source, so a strap change takes effect on the next pclk edge.
  assign nxt_dir_out   = dir_by_strap_bit ? !nxt_ctrl[dupsel_pkg::CTRL_DIR_BIT] : nxt_iosel_dir;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign nxt_dout = win_a ? uart_a_rdata : (win_b ? uart_b_rdata : pp_rd_data);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // All state runs from pclk; no private oscillator exists.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_dly_ff <= 1'b0;
      addr_ff   <= 3'h0;
      wsel_a_ff <= 1'b0;
      wsel_b_ff <= 1'b0;
      wsel_p_ff <= 1'b0;
      wdata_ff  <= 8'h00;
    end else begin
      wr_dly_ff <= wr_lvl;
      if (wr_lvl) begin
        addr_ff   <= bus.addr;
        wsel_a_ff <= win_a;
        wsel_b_ff <= win_b;
        wsel_p_ff <= win_p;
        wdata_ff  <= bus.data_bus;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pp_data_q_ff    <= 8'h00;
      pp_ctrl_q_ff    <= dupsel_pkg::CTRL_RST;
      // Out of reset the port drives, which matches a clear control register.
      pp_dir_out_ff   <= 1'b1;
      pp_iosel_dir_ff <= 1'b1;
    end else begin
      pp_dir_out_ff   <= nxt_dir_out;
      pp_iosel_dir_ff <= nxt_iosel_dir;
      pp_ctrl_q_ff    <= nxt_ctrl;
      if (pp_wr_data) begin
        pp_data_q_ff <= wdata_ff;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_ff <= 8'h00;
    end else begin
      dout_ff <= nxt_dout;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Output data comes from a flop, so it trails the read strobe by one cycle.
  assign bus.dev_dout           = dout_ff;
  assign bus.dev_doe            = rd_act;
  assign bus.read_active_out    = rd_act;
  assign printer_data_lines_out = pp_data_q_ff;
  assign printer_data_lines_oe  = pp_dir_out_ff;
  // Released, the line rests high on its pull-up outside this block.
  assign auto_linefeed_n_out    = 1'b0;
  // Open drain: only ever pulls low, never drives high.
  assign auto_linefeed_n_oe     = pp_ctrl_q_ff[dupsel_pkg::CTRL_ALF_BIT];
endmodule // dupsel_device

// [verilog/dupsel_host.sv]
// Purpose: Host controller end, driven by software over APB.
// Assumes: pclk shared with the device end.
// Notes:   One bus cycle per command; status shows busy.
`timescale 1ns/100ps
module dupsel_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  dupsel_if.host           bus
);
  typedef enum logic [1:0] {IDLE, STROBE, HOLD} dupsel_st_t;
  dupsel_st_t st_ff;
  logic [2:0] cnt_ff;
  logic [2:0] addr_ff;
  logic [1:0] cs_ff;
  logic       wr_ff;
  logic [7:0] wdata_ff, rdata_ff;

  wire acc   = psel & penable;
  wire go    = acc & pwrite & (paddr == dupsel_pkg::CMD_OFS) & pwdata[dupsel_pkg::CMD_GO_BIT] & (st_ff == IDLE);
  wire wd_wr = acc & pwrite & (paddr == dupsel_pkg::WDATA_OFS);
  wire busy  = (st_ff != IDLE);
  wire known = (paddr == dupsel_pkg::CMD_OFS) | (paddr == dupsel_pkg::WDATA_OFS) |
               (paddr == dupsel_pkg::STATUS_OFS) | (paddr == dupsel_pkg::RDATA_OFS);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & !known;
  assign prdata  = (paddr == dupsel_pkg::STATUS_OFS) ? {31'h0, busy} :
                   (paddr == dupsel_pkg::RDATA_OFS)  ? {24'h0, rdata_ff} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff    <= IDLE;
      cnt_ff   <= 3'h0;
      addr_ff  <= 3'h0;
      cs_ff    <= dupsel_pkg::CS_UART_A;
      wr_ff    <= 1'b0;
      wdata_ff <= 8'h00;
      rdata_ff <= 8'h00;
    end else begin
      if (wd_wr) begin
        wdata_ff <= pwdata[7:0];
      end
      case (st_ff)
        IDLE: begin
          if (go) begin
            addr_ff <= pwdata[2:0];
            wr_ff   <= pwdata[dupsel_pkg::CMD_WR_BIT];
            cs_ff   <= pwdata[dupsel_pkg::CMD_CS_LSB +: 2];
            cnt_ff  <= 3'h0;
            st_ff   <= STROBE;
          end
        end
        STROBE: begin
          cnt_ff <= cnt_ff + 3'h1;
          if (cnt_ff == dupsel_pkg::STROBE_CYC) begin
            if (!wr_ff) begin
              rdata_ff <= bus.data_bus;
            end
            st_ff <= HOLD;
          end
        end
        HOLD:    st_ff <= IDLE;
        default: st_ff <= IDLE;
      endcase
    end
  end

  wire cyc = (st_ff != IDLE);
  assign bus.addr                  = addr_ff;
  assign bus.uart_a_select_n       = !(cyc & (cs_ff == dupsel_pkg::CS_UART_A));
  assign bus.uart_b_select_n       = !(cyc & (cs_ff == dupsel_pkg::CS_UART_B));
  assign bus.printer_port_select_n = !(cyc & (cs_ff == dupsel_pkg::CS_PRINTER));
  assign bus.host_read_strobe_n    = !((st_ff == STROBE) & !wr_ff);
  assign bus.host_write_strobe_n   = !((st_ff == STROBE) & wr_ff);
  assign bus.host_dout             = wdata_ff;
  assign bus.host_doe              = cyc & wr_ff; // Host drives only on writes.
endmodule // dupsel_host

// [verification/dupsel_monitor.sv]
// Purpose: Checks the pin link between the host controller and the device end.
// Assumes: One clock; selects and strobes are active low levels.
// Notes:   The strobe length is the controller's fixed four cycles.
`timescale 1ns/100ps
module dupsel_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       uart_a_select_n,
  input wire logic       uart_b_select_n,
  input wire logic       printer_port_select_n,
  input wire logic       host_read_strobe_n,
  input wire logic       host_write_strobe_n,
  input wire logic [2:0] addr,
  input wire logic       host_doe,
  input wire logic       dev_doe,
  input wire logic       read_active_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire any_sel = !uart_a_select_n || !uart_b_select_n || !printer_port_select_n;
  wire rd_n    = host_read_strobe_n;
  a_read_active_out_follows: assert property (read_active_out == (any_sel && !rd_n))
    else $error("read active output does not match select and read strobe");
  a_dev_drive_read: assert property (dev_doe |-> any_sel && !rd_n)
    else $error("device drives the bus outside a read");
  a_host_quiet_rd: assert property (!rd_n |-> !host_doe)
    else $error("host drives the bus during a read");
  a_idle_no_drive: assert property (!any_sel |-> !dev_doe)
    else $error("device drives the bus with no select low");
  a_strobe_has_sel: assert property (!(rd_n && host_write_strobe_n) |-> any_sel)
    else $error("strobe low with no select low");
  a_one_select: assert property ($onehot0({!uart_a_select_n, !uart_b_select_n, !printer_port_select_n}))
    else $error("more than one select low");
  a_read_len: assert property ($fell(rd_n) |-> !rd_n [*4] ##1 rd_n)
    else $error("read strobe not low for four cycles");
  a_addr_steady: assert property (!rd_n && !$past(rd_n) |-> $stable(addr))
    else $error("address moved during a read strobe");
endmodule // dupsel_monitor

// [verification/dual_uart_printer_host_select_tb.sv]
// Purpose: Self-checking bench for the host controller and device end joined by the link.
// Assumes: The APB slave answers at once; pready is still polled.
// Notes:   The reference model keeps register images in integer arrays.
`timescale 1ns/100ps
module dual_uart_printer_host_select_tb;
  logic        pclk, pready, pslverr, e, pd_oe, alf_out, alf_oe;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        strap = 1'b0, ack_n = 1'b1, busy = 1'b0;
  logic [7:0]  paddr = 8'h00, pd_drv = 8'h00, pd_out, v;
  logic [31:0] pwdata = 32'h0, prdata, r;
  int          bad_count, checked, seed, ua[16], i;
  // The wire model: open-drain line pulled up, data pins owned by whoever drives.
  wire         alf_in = alf_oe ? alf_out : 1'b1;
  wire [7:0]   pd_in  = pd_oe ? pd_out : pd_drv;
  dupsel_if ifc();
  dupsel_host dupsel_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(ifc.host));
  dupsel_device dupsel_device_i (.pclk(pclk), .presetn(presetn), .bus(ifc.dev), .direction_source_strap(strap),
    .printer_ack_n(ack_n), .printer_busy(busy), .printer_data_lines_in(pd_in), .printer_data_lines_out(pd_out),
    .printer_data_lines_oe(pd_oe), .auto_linefeed_n_in(alf_in), .auto_linefeed_n_out(alf_out),
    .auto_linefeed_n_oe(alf_oe));
  dupsel_monitor dupsel_monitor_i (.pclk(pclk), .presetn(presetn), .uart_a_select_n(ifc.uart_a_select_n),
    .uart_b_select_n(ifc.uart_b_select_n), .printer_port_select_n(ifc.printer_port_select_n),
    .host_read_strobe_n(ifc.host_read_strobe_n), .host_write_strobe_n(ifc.host_write_strobe_n),
    .addr(ifc.addr), .host_doe(ifc.host_doe), .dev_doe(ifc.dev_doe), .read_active_out(ifc.read_active_out));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_d(input logic [7:0] g, input logic [7:0] x);
    checked++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chk_f(input logic g, input logic x);
    chk_d({7'h0, g}, {7'h0, x});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One link transfer: load data, issue the command, then poll busy under a bound.
  task automatic op(input logic [1:0] cs, input logic w, input logic [2:0] a, input logic [7:0] d);
    apb(1'b1, dupsel_pkg::WDATA_OFS, {24'h0, d});
    apb(1'b1, dupsel_pkg::CMD_OFS, {20'h0, cs, w, 1'b1, 5'h0, a});
    i = 0;
    do begin
      apb(1'b0, dupsel_pkg::STATUS_OFS, 32'h0);
      i++;
    end while (r[0] !== 1'b0 && i < 40);
    chk_f(r[0], 1'b0);
    if (!w) apb(1'b0, dupsel_pkg::RDATA_OFS, 32'h0);
  endtask
  task automatic rd(input logic [1:0] cs, input logic [2:0] a, input logic [7:0] x);
    op(cs, 1'b0, a, 8'h00);
    chk_d(r[7:0], x);
  endtask
  task automatic wp(input logic [1:0] a, input logic [7:0] d);
    op(dupsel_pkg::CS_PRINTER, 1'b1, {1'b0, a}, d);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    complete_run();
  end
  initial begin
    seed = 32'hc74d2974;
    repeat (12) @(posedge pclk);
    chk_f(pd_oe, 1'b1);
    presetn <= 1'b1;
    chk_d(ifc.data_bus, 8'hff);
    for (int k = 0; k < 16; k++) begin
      ua[k] = $random(seed) & 8'hff;
      op(2'(k / 8), 1'b1, 3'(k % 8), 8'(ua[k]));
    end
    for (int k = 15; k >= 0; k--) rd(2'(k / 8), 3'(k % 8), 8'(ua[k]));
    wp(dupsel_pkg::PP_IOSEL_OFS, dupsel_pkg::DIR_OUT_PAT);
    chk_f(pd_oe, 1'b1);
    v = 8'($random(seed));
    wp(dupsel_pkg::PP_DATA_OFS, v);
    chk_d(pd_out, v);
    rd(dupsel_pkg::CS_PRINTER, 3'h0, v);
    wp(dupsel_pkg::PP_IOSEL_OFS, dupsel_pkg::DIR_IN_PAT);
    chk_f(pd_oe, 1'b0);
    wp(dupsel_pkg::PP_IOSEL_OFS, 8'h12);
    chk_f(pd_oe, 1'b0);
    rd(dupsel_pkg::CS_PRINTER, 3'h3, 8'h00);
    wp(dupsel_pkg::PP_CTRL_OFS, 8'h00);
    chk_f(pd_oe, 1'b0);
    v = 8'($random(seed));
    pd_drv <= v;
    rd(dupsel_pkg::CS_PRINTER, 3'h0, v);
    strap <= 1'b1;
    wp(dupsel_pkg::PP_IOSEL_OFS, dupsel_pkg::DIR_IN_PAT);
    chk_f(pd_oe, 1'b1);
    wp(dupsel_pkg::PP_CTRL_OFS, 8'h22);
    chk_f(pd_oe, 1'b0);
    chk_f(alf_in, 1'b0);
    wp(dupsel_pkg::PP_CTRL_OFS, 8'h00);
    chk_f(pd_oe, 1'b1);
    chk_f(alf_oe, 1'b0);
    for (int k = 0; k < 4; k++) begin
      busy <= k[1];
      ack_n <= k[0];
      rd(dupsel_pkg::CS_PRINTER, 3'h1, {k[1], k[0], 6'h0});
    end
    apb(1'b0, 8'h10, 32'h0);
    chk_f(e, 1'b1);
    chk_d(r[7:0], 8'h00);
    chk_d(ifc.data_bus, 8'hff);
    complete_run();
  end
endmodule // dual_uart_printer_host_select_tb
